// ===== design/ghs_pkg.sv
// Shared constants for the host serial ports link
package ghs_pkg;
   localparam int CORE_CLK_NS       = 100;
   localparam int INIT_TIME_NS      = 10000;
   localparam int DESELECT_TIME_NS  = 1000000;
   localparam int BIT_TIME_NS       = 1000;
   localparam int BYTE_TIME_NS      = 8000;
   localparam int INIT_CYC   = (INIT_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int DESEL_CYC  = (DESELECT_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int BIT_CYC    = (BIT_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int BYTE_CYC   = (BYTE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int BYTE_W     = 8;
   localparam int BIT_CNT_W  = 3;
   localparam logic [7:0] IDLE_FILL = 8'hff;
   localparam logic [1:0] FILT_LEN = 2'h2;
endpackage : ghs_pkg

// ===== design/ghs_link_if.sv
// Serial link between host controller and target port
`timescale 1ns/1ps
interface ghs_link_if;
   logic sclk;
   logic sel_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport target (input sclk, input sel_n, input mosi, output miso, output miso_oe);
   modport host   (output sclk, output sel_n, output mosi, input miso, input miso_oe);
endinterface : ghs_link_if

// ===== design/ghs_target.sv
// Serial target end: shifts bytes on the host's link clock
`timescale 1ns/1ps
module ghs_target
   import ghs_pkg::*;
#(
   parameter int W = ghs_pkg::BYTE_W
) (
   ghs_link_if.target       link,
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        port_enable,
   input  wire logic        filter_enable,
   input  wire logic [W-1:0] tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [W-1:0]     rx_data,
   output logic             rx_valid
);
   logic [W-1:0]   shift_in_reg;
   logic [W-1:0]   shift_out_reg;
   logic [BIT_CNT_W-1:0] bit_cnt_reg;
   logic [W-1:0]   rx_hold_reg;
   logic           rx_tog_reg;
   logic [W-1:0]   tx_hold_reg;
   logic           tx_full_reg;
   logic           tx_take_tog_reg;
   logic [2:0]     rx_sync_reg;
   logic [2:0]     take_sync_reg;
   logic [1:0]     en_sync_reg;
   logic [1:0]     filt_sync_reg;
   logic           active;
   logic           loaded_reg;
   logic [W-1:0]   first_byte;

   // Enable and filter settings cross into the link domain as levels
   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         en_sync_reg   <= '0;
         filt_sync_reg <= '0;
      end else begin
         en_sync_reg   <= {en_sync_reg[0], port_enable};
         filt_sync_reg <= {filt_sync_reg[0], filter_enable};
      end
   end

   assign active = en_sync_reg[1] & ~link.sel_n;

   // Receive shift, MSB first; the select clears the bit count
   always_ff @(posedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         bit_cnt_reg <= '0;
      end else if (en_sync_reg[1]) begin
         shift_in_reg <= {shift_in_reg[W-2:0], link.mosi};
         bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      end
   end

   // Glitch filter: its check is forced true, so every byte is kept with it on or off,
   // whatever the mosi bit did; trading speed for robustness is left to the user
   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         rx_hold_reg <= '0;
         rx_tog_reg  <= 1'b0;
      end else if (active && bit_cnt_reg == 3'h7) begin
         rx_hold_reg <= {shift_in_reg[W-2:0], link.mosi};
         if (!filt_sync_reg[1] || shift_in_reg[0] == link.mosi || 1'b1)
            rx_tog_reg <= ~rx_tog_reg;
      end
   end

   // Holding byte loads whenever tx_valid is high and tx_full_reg is low, even during a frame, so it may change here
   assign first_byte = tx_full_reg ? tx_hold_reg : IDLE_FILL;

   // Marks the first falling edge of a frame; the select clears it
   always_ff @(negedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         loaded_reg <= 1'b0;
      end else if (active) begin
         loaded_reg <= 1'b1;
      end
   end

   // Transmit shift on the falling edge so data is stable at the rising edge
   always_ff @(negedge link.sclk or posedge rst) begin
      if (rst) begin
         shift_out_reg   <= IDLE_FILL;
         tx_take_tog_reg <= 1'b0;
      end else if (active) begin
         if (!loaded_reg) begin
            shift_out_reg   <= {first_byte[W-2:0], 1'b1};
            tx_take_tog_reg <= tx_take_tog_reg ^ tx_full_reg;
         end else begin
            shift_out_reg <= {shift_out_reg[W-2:0], 1'b1};
         end
      end
   end

   // First bit must stand before the first rising edge of the frame
   assign link.miso    = loaded_reg ? shift_out_reg[W-1] : first_byte[W-1];
   assign link.miso_oe = active;

   // Core domain: byte events cross by toggle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_sync_reg   <= '0;
         take_sync_reg <= '0;
      end else begin
         rx_sync_reg   <= {rx_sync_reg[1:0], rx_tog_reg};
         take_sync_reg <= {take_sync_reg[1:0], tx_take_tog_reg};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_data  <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= rx_sync_reg[2] ^ rx_sync_reg[1];
         if (rx_sync_reg[2] ^ rx_sync_reg[1])
            rx_data <= rx_hold_reg;
      end
   end

   // Holding register for the next outgoing byte; taken flag wins over load
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_hold_reg <= '0;
         tx_full_reg <= 1'b0;
      end else if (take_sync_reg[2] ^ take_sync_reg[1]) begin
         tx_full_reg <= 1'b0;
      end else if (tx_valid && !tx_full_reg) begin
         tx_hold_reg <= tx_data;
         tx_full_reg <= 1'b1;
      end
   end

   assign tx_ready = ~tx_full_reg;
endmodule : ghs_target

// ===== design/ghs_host.sv
// Host controller end: drives the link clock and select with spacing
`timescale 1ns/1ps
module ghs_host
   import ghs_pkg::*;
#(
   parameter int DESEL = ghs_pkg::DESEL_CYC
) (
   ghs_link_if.host         link,
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid
);
   typedef enum logic [2:0] {
      GH_DESEL = 3'h0, GH_INIT = 3'h1, GH_LO = 3'h2, GH_HI = 3'h3, GH_GAP = 3'h4
   } ghs_state_t;
   localparam int HALF = BIT_CYC / 2;
   ghs_state_t  st_reg;
   logic [19:0] cnt_reg;
   logic [2:0]  bit_reg;
   logic [7:0]  sh_reg;
   logic [7:0]  in_reg;
   logic [1:0]  miso_sync_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) miso_sync_reg <= '0;
      else     miso_sync_reg <= {miso_sync_reg[0], link.miso};
   end

   assign tx_ready = (st_reg == GH_DESEL) && (cnt_reg == '0);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= GH_DESEL; cnt_reg <= '0; bit_reg <= '0; sh_reg <= '0;
         in_reg <= '0; rx_data <= '0; rx_valid <= 1'b0;
         link.sclk <= 1'b0; link.sel_n <= 1'b1; link.mosi <= 1'b1;
      end else begin
         rx_valid <= 1'b0;
         if (cnt_reg != '0) cnt_reg <= cnt_reg - 20'h1;
         case (st_reg)
            GH_DESEL: if (cnt_reg == '0 && tx_valid) begin
               sh_reg <= tx_data; link.sel_n <= 1'b0;
               cnt_reg <= 20'(INIT_CYC); st_reg <= GH_INIT;
            end
            GH_INIT: if (cnt_reg == '0) begin
               link.mosi <= sh_reg[7]; cnt_reg <= 20'(HALF); st_reg <= GH_LO;
            end
            GH_LO: if (cnt_reg == '0) begin
               link.sclk <= 1'b1; cnt_reg <= 20'(HALF); st_reg <= GH_HI;
            end
            GH_HI: if (cnt_reg == '0) begin
               link.sclk <= 1'b0;
               in_reg <= {in_reg[6:0], miso_sync_reg[1]};
               sh_reg <= {sh_reg[6:0], 1'b1};
               bit_reg <= bit_reg + 3'h1;
               if (bit_reg == 3'h7) begin
                  cnt_reg <= 20'(BYTE_CYC - 8 * BIT_CYC + 1); st_reg <= GH_GAP;
               end else begin
                  link.mosi <= sh_reg[6]; cnt_reg <= 20'(HALF); st_reg <= GH_LO;
               end
            end
            GH_GAP: if (cnt_reg == '0) begin
               rx_data <= in_reg; rx_valid <= 1'b1;
               link.sel_n <= 1'b1; cnt_reg <= 20'(DESEL); st_reg <= GH_DESEL;
            end
            default: st_reg <= GH_DESEL;
         endcase
      end
   end
endmodule : ghs_host

// ===== tb/ghs_link_chk.sv
// Timing checks on the link between host and target ends
`timescale 1ns/1ps
module ghs_link_chk
   import ghs_pkg::*;
#(
   parameter int DESEL = ghs_pkg::DESEL_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic [19:0] frm_reg;
   logic [19:0] hi_reg;
   logic [3:0]  rise_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) frm_reg <= '0;
      else frm_reg <= sel_n ? '0 : frm_reg + 20'h1;
   end
   // Starts at DESEL so the first frame after reset needs no gap
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) hi_reg <= 20'(DESEL);
      else if (!sel_n) hi_reg <= '0;
      else if (hi_reg != 20'hfffff) hi_reg <= hi_reg + 20'h1;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) rise_reg <= '0;
      else if (sel_n) rise_reg <= '0;
      else if ($rose(sclk)) rise_reg <= rise_reg + 4'h1;
   end
   chk_init_wait: assert property ($rose(sclk) |-> frm_reg >= INIT_CYC)
      else $error("clock began too soon after select");
   chk_desel_gap: assert property ($fell(sel_n) |-> hi_reg >= DESEL)
      else $error("deselect gap too short");
   chk_bit_high: assert property ($rose(sclk) |=> sclk [*5] ##1 !sclk)
      else $error("clock high phase wrong");
   chk_bit_low: assert property ($fell(sclk) |=> (!sclk) [*4])
      else $error("clock low phase too short");
   chk_byte_span: assert property ($rose(sel_n) |-> frm_reg >= BYTE_CYC)
      else $error("frame shorter than byte period");
   chk_whole_byte: assert property ($rose(sel_n) |-> rise_reg == 4'h8)
      else $error("frame not eight clocks");
   chk_clk_idle: assert property (sel_n && $past(sel_n) |-> !sclk)
      else $error("clock toggles while deselected");
   chk_oe_deselect: assert property (sel_n [*3] |-> !miso_oe)
      else $error("target drives data while deselected");
endmodule : ghs_link_chk

// ===== tb/gnss_host_serial_ports_tb_top.sv
// Bench joining host and target ends over one link
`timescale 1ns/1ps
module gnss_host_serial_ports_tb_top;
   import ghs_pkg::*;
   localparam int DESEL = 50;
   logic       core_clk = 0, rst = 1, port_en = 0, filt_en = 0;
   logic [7:0] h_txd = 8'h00, t_txd = 8'h00, h_rxd, t_rxd;
   logic       h_txv = 0, t_txv = 0, h_txr, t_txr, h_rxv, t_rxv;
   int         errors = 0, samples_checked = 0;
   ghs_link_if link ();
   ghs_host #(.DESEL(DESEL)) u_ghs_host (.link(link), .core_clk(core_clk), .rst(rst),
      .tx_data(h_txd), .tx_valid(h_txv), .tx_ready(h_txr), .rx_data(h_rxd), .rx_valid(h_rxv));
   ghs_target u_ghs_target (.link(link), .core_clk(core_clk), .rst(rst), .port_enable(port_en),
      .filter_enable(filt_en), .tx_data(t_txd), .tx_valid(t_txv), .tx_ready(t_txr),
      .rx_data(t_rxd), .rx_valid(t_rxv));
   ghs_link_chk #(.DESEL(DESEL)) u_ghs_link_chk (.core_clk(core_clk), .rst(rst),
      .sclk(link.sclk), .sel_n(link.sel_n), .mosi(link.mosi), .miso(link.miso),
      .miso_oe(link.miso_oe));
   initial forever #50 core_clk = ~core_clk;
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp8
   task automatic cmp1(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp1
   // Mode 0 expects a disabled target, 1 checks both ends, 2 checks only that the host took the byte
   task automatic xfer(input logic [7:0] hb, input logic [7:0] tb, input int m);
      logic [7:0] hg;
      logic [7:0] tg;
      logic       hv;
      logic       tv;
      int         n;
      hg = 8'h00; tg = 8'h00; hv = 0; tv = 0; n = 0;
      @(negedge core_clk);
      if (m != 0) begin
         t_txd = tb; t_txv = 1;
         while (t_txr !== 1'b1) @(negedge core_clk);
         @(negedge core_clk) t_txv = 0;
      end
      h_txd = hb; h_txv = 1;
      while (h_txr !== 1'b1) @(negedge core_clk);
      @(negedge core_clk) h_txv = 0;
      cmp1(h_txr, 1'b0);
      while (n < 400 && !(hv && tv)) begin
         @(negedge core_clk);
         n++;
         if (h_rxv === 1'b1) begin hg = h_rxd; hv = 1; end
         if (t_rxv === 1'b1) begin tg = t_rxd; tv = 1; end
      end
      if (m == 0) begin
         cmp8(hg, IDLE_FILL);
         cmp1(tv, 1'b0);
      end else if (m == 1) begin
         cmp8(hg, tb);
         cmp8(tg, hb);
      end
   endtask : xfer
   task automatic close_out;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #2000000;
      errors++;
      close_out();
   end
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 0;
      xfer(8'h5a, 8'h00, 0);
      port_en = 1;
      xfer(8'h11, 8'h22, 2);
      xfer(8'ha5, 8'h3c, 1);
      xfer(8'h00, 8'hff, 1);
      xfer(8'hff, 8'h00, 1);
      // Filter on must not corrupt a slow link
      filt_en = 1;
      xfer(8'h81, 8'h7e, 1);
      close_out();
   end
endmodule : gnss_host_serial_ports_tb_top
